/* File: src/byte_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_reg + (AW+1)'(push);
      rd_reg <= rd_reg + (AW+1)'(pop);
    end
  end
endmodule : byte_fifo
`default_nettype wire

/* File: src/i2c_bus_master.sv */
// master end: takes command bytes from a fifo and clocks them out on the link
// assumes the user queues one transaction at a time
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master #(
  parameter int unsigned HALF = rtc_pkg::SCL_HALF_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // link
  i2c_link_if.master      link,
  // command stream: bit8 high = last byte (send stop after it)
  input  wire logic [8:0] cmd_data,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  // status
  output logic            nack,
  output logic            busy
);
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_FLUSH} mstate_e;
  mstate_e     st_reg;
  logic [8:0]  f_data;
  logic        f_valid, f_pop;
  logic [15:0] cnt_reg;
  logic [1:0]  ph_reg;
  logic [3:0]  bit_reg;
  logic [1:0]  sda_s;
  logic        scl_oe_n_reg, sda_oe_n_reg;
  logic        drop_reg;

  byte_fifo #(.WIDTH(9), .DEPTH(16)) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .in_data  (cmd_data),
    .in_valid (cmd_valid),
    .in_ready (cmd_ready),
    .out_data (f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sda_s <= 2'h3;
    end else begin
      sda_s <= {sda_s[0], link.sda};
    end
  end

  wire tick = cnt_reg == 16'(HALF - 1);
  assign f_pop = (st_reg == M_ACK && tick && ph_reg == 2'h3) || (st_reg == M_FLUSH && f_valid);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg       <= M_IDLE;
      cnt_reg      <= '0;
      ph_reg       <= '0;
      bit_reg      <= '0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      nack         <= 1'b0;
      busy         <= 1'b0;
      drop_reg     <= 1'b0;
    end else begin
      cnt_reg <= tick ? 16'h0 : cnt_reg + 16'h1;
      case (st_reg)
        M_IDLE: begin
          busy <= 1'b0;
          if (f_valid && tick) begin
            st_reg <= M_START;
            busy <= 1'b1;
            nack <= 1'b0;
          end
        end
        M_START: if (tick) begin
          sda_oe_n_reg <= 1'b0;
          st_reg <= M_BIT;
          ph_reg <= '0;
          bit_reg <= '0;
        end
        M_BIT: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: scl_oe_n_reg <= 1'b0;
            2'h1: sda_oe_n_reg <= f_data[7 - 3'(bit_reg)];
            2'h2: scl_oe_n_reg <= 1'b1;
            default: begin
              scl_oe_n_reg <= 1'b0;
              if (bit_reg == 4'h7) begin
                st_reg <= M_ACK;
              end
              bit_reg <= bit_reg + 4'h1;
            end
          endcase
        end
        M_ACK: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_oe_n_reg <= 1'b1;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: nack <= nack | sda_s[1];
            default: begin
              scl_oe_n_reg <= 1'b0;
              bit_reg <= '0;
              st_reg <= (f_data[8] || nack) ? M_STOP : M_BIT;
              drop_reg <= nack && !f_data[8];
            end
          endcase
        end
        M_STOP: if (tick) begin
          ph_reg <= ph_reg + 2'h1;
          case (ph_reg)
            2'h0: sda_oe_n_reg <= 1'b0;
            2'h1: scl_oe_n_reg <= 1'b1;
            2'h2: sda_oe_n_reg <= 1'b1;
            default: st_reg <= drop_reg ? M_FLUSH : M_IDLE;
          endcase
        end
        // a refused transaction leaves its remaining bytes queued; drop them up to the last
        M_FLUSH: begin
          if (f_valid && f_data[8]) begin
            st_reg <= M_IDLE;
          end
        end
        default: st_reg <= M_IDLE;
      endcase
    end
  end

  assign link.scl_oe_n   = scl_oe_n_reg;
  assign link.sda_m_oe_n = sda_oe_n_reg;
endmodule : i2c_bus_master
`default_nettype wire

/* File: src/i2c_link_if.sv */
// two-wire link between the master end and the slave end
// open-drain lines resolved here, sda from the two data enables and scl from the master enable alone (low enable = pulling low)
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl_oe_n;
  logic sda_m_oe_n;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  assign scl = scl_oe_n;
  assign sda = sda_m_oe_n & sda_s_oe_n;
  modport master (output scl_oe_n, output sda_m_oe_n, input scl, input sda);
  modport slave  (output sda_s_oe_n, input scl, input sda);
endinterface : i2c_link_if
`default_nettype wire

/* File: src/rtc_pkg.sv */
// constants shared by the serial slave and the bus master
// assumes a 50 MHz system clock on both ends
package rtc_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned RESET_DELAY_MS  = 250;
  localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned WRITE_TIME_MS   = 5;
  localparam int unsigned WRITE_TIME_CYC  = WRITE_TIME_MS * (CLK_HZ / 1000);
  localparam logic [6:0]  ARRAY_ID        = 7'h57;
  localparam logic [6:0]  REG_ID          = 7'h6F;
  localparam int unsigned ARRAY_PAGE      = 16;
  localparam int unsigned REG_PAGE        = 8;
  localparam int unsigned ARRAY_WORDS     = 512;
  localparam int unsigned REG_WORDS       = 64;
  localparam logic [15:0] STATUS_ADDR     = 16'h003F;
  localparam logic [7:0]  UNLOCK_1        = 8'h02;
  localparam logic [7:0]  UNLOCK_2        = 8'h06;
  localparam logic [15:0] PROTECT_BASE    = 16'h0180;
  localparam int unsigned SCL_HALF_CYC    = 125;
endpackage : rtc_pkg

/* File: src/rtc_serial_slave.sv */
// serial slave end: start/stop detection, addressing, page buffer, nonvolatile write
// assumes scl/sda arrive asynchronously; supply status pins are async levels
`timescale 1ns/1ps
`default_nettype none
module rtc_serial_slave #(
  parameter int unsigned RESET_DELAY = rtc_pkg::RESET_DELAY_CYC,
  parameter int unsigned WRITE_TIME  = rtc_pkg::WRITE_TIME_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // link
  i2c_link_if.slave link,
  // supply supervision
  input  wire logic supply_low,
  input  wire logic on_battery,
  input  wire logic protect_en,
  output logic      reset_out_n,
  output logic      write_busy
);
  typedef enum {S_IDLE, S_SLAVE, S_ADDR_HI, S_ADDR_LO, S_WDATA, S_RDATA, S_RACK,
                S_ACK} state_e;
  logic [1:0] scl_s, sda_s, low_s, bat_s, prot_s;
  logic       scl_d, sda_d;
  logic       scl_rise, scl_fall, start_det, stop_det, low_voltage_reset_detector;
  state_e     state_reg, ret_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg, tx_reg;
  logic [15:0] addr_reg;
  logic       space_reg, rd_reg, ack_reg, got_byte_reg, sda_oe_n_reg;
  logic [31:0] rst_cnt_reg, wr_cnt_reg;
  logic [7:0] page_buf [rtc_pkg::ARRAY_PAGE];
  logic [rtc_pkg::ARRAY_PAGE-1:0] dirty_reg;
  logic [7:0] array_mem [rtc_pkg::ARRAY_WORDS];
  logic [7:0] reg_mem   [rtc_pkg::REG_WORDS];
  logic       wel_reg, register_write_enable_latch_reg, status_hit_reg;
  logic [7:0] status_val_reg;
  logic [15:0] page_base_reg;

  function automatic logic [15:0] page_step(input logic [15:0] a, input logic sp);
    page_step = sp ? {a[15:3], 3'(a[2:0] + 3'h1)} : {a[15:4], 4'(a[3:0] + 4'h1)};
  endfunction : page_step

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      low_s <= 2'h0;
      bat_s <= 2'h0;
      prot_s <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], link.scl};
      sda_s <= {sda_s[0], link.sda};
      low_s <= {low_s[0], supply_low};
      bat_s <= {bat_s[0], on_battery};
      prot_s <= {prot_s[0], protect_en};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  assign scl_rise  = scl_s[1] & ~scl_d;
  assign scl_fall  = ~scl_s[1] & scl_d;
  assign start_det = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  assign low_voltage_reset_detector       = ~reset_out_n;

  ////////////////////////////////////////////////////////////////////////////
  // reset supervisor: a long hold-off so a flickering supply cannot start traffic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_cnt_reg <= '0;
      reset_out_n <= 1'b0;
    end else if (low_s[1]) begin
      rst_cnt_reg <= '0;
      reset_out_n <= 1'b0;
    end else if (rst_cnt_reg < RESET_DELAY - 1) begin
      rst_cnt_reg <= rst_cnt_reg + 32'h1;
    end else begin
      reset_out_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile write engine; busy blanks the serial side entirely
  logic commit;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      write_busy <= 1'b0;
      wr_cnt_reg <= '0;
    end else if (commit) begin
      write_busy <= 1'b1;
      wr_cnt_reg <= '0;
    end else if (write_busy) begin
      if (low_voltage_reset_detector && bat_s[1]) begin
        write_busy <= 1'b0;
      end else if (wr_cnt_reg >= WRITE_TIME - 1) begin
        write_busy <= 1'b0;
      end else begin
        wr_cnt_reg <= wr_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (write_busy && !(low_voltage_reset_detector && bat_s[1]) && wr_cnt_reg >= WRITE_TIME - 1) begin
      for (int i = 0; i < rtc_pkg::ARRAY_PAGE; i++) begin
        if (dirty_reg[i]) begin
          if (space_reg) begin
            reg_mem[6'(page_base_reg[5:0] + 6'(i))] <= page_buf[i];
          end else begin
            array_mem[9'(page_base_reg[8:0] + 9'(i))] <= page_buf[i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the stop's own clock rise counts as one bit, so up to one bit is still a clean stop
  assign commit = stop_det && state_reg == S_WDATA && bit_reg <= 4'h1 && got_byte_reg
                  && !status_hit_reg && (|dirty_reg) && !write_busy && !low_voltage_reset_detector;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg    <= S_IDLE;
      ret_reg      <= S_IDLE;
      bit_reg      <= '0;
      sh_reg       <= '0;
      tx_reg       <= '0;
      addr_reg     <= 16'h0000;
      space_reg    <= 1'b0;
      rd_reg       <= 1'b0;
      ack_reg      <= 1'b0;
      got_byte_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      dirty_reg    <= '0;
      wel_reg      <= 1'b0;
      register_write_enable_latch_reg     <= 1'b0;
      status_hit_reg <= 1'b0;
      status_val_reg <= '0;
      page_base_reg <= '0;
    end else if (low_voltage_reset_detector || write_busy) begin
      state_reg    <= S_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else if (start_det) begin
      state_reg    <= S_SLAVE;
      bit_reg      <= '0;
      sda_oe_n_reg <= 1'b1;
      dirty_reg    <= '0;
      got_byte_reg <= 1'b0;
      status_hit_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg    <= S_IDLE;
      sda_oe_n_reg <= 1'b1;
      // the address has already stepped past the status byte, so its hit was latched at ack
      if (state_reg == S_WDATA && status_hit_reg && bit_reg <= 4'h1) begin
        if (status_val_reg == 8'h00) begin
          wel_reg  <= 1'b0;
          register_write_enable_latch_reg <= 1'b0;
        end else if (status_val_reg == rtc_pkg::UNLOCK_1) begin
          wel_reg <= 1'b1;
        end else if (status_val_reg == rtc_pkg::UNLOCK_2 && wel_reg) begin
          register_write_enable_latch_reg <= 1'b1;
        end
        dirty_reg <= '0;
      end
      if (commit && space_reg) begin
        register_write_enable_latch_reg <= 1'b0;
      end
    end else begin
      case (state_reg)
        S_IDLE: begin
          sda_oe_n_reg <= 1'b1;
        end
        S_SLAVE, S_ADDR_HI, S_ADDR_LO, S_WDATA: begin
          if (scl_rise) begin
            sh_reg  <= {sh_reg[6:0], sda_s[1]};
            bit_reg <= bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == 4'h8) begin
            bit_reg <= '0;
            ret_reg <= state_reg;
            state_reg <= S_ACK;
            if (state_reg == S_SLAVE) begin
              rd_reg    <= sh_reg[0];
              space_reg <= sh_reg[7:4] == 4'hD;
              ack_reg   <= sh_reg[7:1] == rtc_pkg::ARRAY_ID || sh_reg[7:1] == rtc_pkg::REG_ID;
              sda_oe_n_reg <= !(sh_reg[7:1] == rtc_pkg::ARRAY_ID || sh_reg[7:1] == rtc_pkg::REG_ID);
            end else begin
              sda_oe_n_reg <= 1'b0;
              if (state_reg == S_ADDR_HI) begin
                addr_reg[15:8] <= sh_reg;
              end else if (state_reg == S_ADDR_LO) begin
                addr_reg[7:0] <= sh_reg;
                page_base_reg <= space_reg ? {addr_reg[15:8], sh_reg[7:3], 3'h0}
                                           : {addr_reg[15:8], sh_reg[7:4], 4'h0};
              end else begin
                got_byte_reg <= 1'b1;
                if (space_reg && addr_reg == rtc_pkg::STATUS_ADDR) begin
                  status_hit_reg <= 1'b1;
                  status_val_reg <= sh_reg;
                end
                addr_reg <= page_step(addr_reg, space_reg);
                if ((space_reg ? register_write_enable_latch_reg || addr_reg == rtc_pkg::STATUS_ADDR
                               : !(prot_s[1] && addr_reg >= rtc_pkg::PROTECT_BASE))) begin
                  page_buf[space_reg ? 4'(addr_reg[2:0]) : addr_reg[3:0]] <= sh_reg;
                  dirty_reg[space_reg ? 4'(addr_reg[2:0]) : addr_reg[3:0]] <= 1'b1;
                end
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe_n_reg <= 1'b1;
            if (!ack_reg && ret_reg == S_SLAVE) begin
              state_reg <= S_IDLE;
            end else if (ret_reg == S_SLAVE && rd_reg) begin
              tx_reg <= space_reg ? reg_mem[addr_reg[5:0]] : array_mem[addr_reg[8:0]];
              sda_oe_n_reg <= space_reg ? reg_mem[addr_reg[5:0]][7] : array_mem[addr_reg[8:0]][7];
              state_reg <= S_RDATA;
            end else begin
              state_reg <= ret_reg == S_SLAVE ? S_ADDR_HI :
                           ret_reg == S_ADDR_HI ? S_ADDR_LO : S_WDATA;
            end
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= S_RACK;
              bit_reg <= '0;
              addr_reg <= addr_reg + 16'h1;
            end else begin
              sda_oe_n_reg <= tx_reg[6 - 3'(bit_reg)];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            ack_reg <= ~sda_s[1];
          end else if (scl_fall) begin
            if (ack_reg) begin
              tx_reg <= space_reg ? reg_mem[addr_reg[5:0]] : array_mem[addr_reg[8:0]];
              sda_oe_n_reg <= space_reg ? reg_mem[addr_reg[5:0]][7] : array_mem[addr_reg[8:0]][7];
              state_reg <= S_RDATA;
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign link.sda_s_oe_n = sda_oe_n_reg;
endmodule : rtc_serial_slave
`default_nettype wire

/* File: testbench/rtc_eeprom_serial_slave_bench.sv */
// self-checking bench: master end and slave end joined by the link interface
// assumes the master sends write bytes only; nack reflects the last transaction
`timescale 1ns/1ps
`default_nettype none
module rtc_eeprom_serial_slave_bench;
  typedef struct packed {
    logic [7:0]   n;
    logic [159:0] b;
    logic         prot;
    logic         nk;
    logic         wb;
  } row_s;
  localparam int RD = 200;
  localparam int WT = 800;

  logic       clk;
  logic       reset_n;
  logic       supply_low;
  logic       on_battery;
  logic       protect_en;
  logic [8:0] cmd_data;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       nack;
  logic       busy;
  logic       reset_out_n;
  logic       write_busy;
  int         miscompares = 0;
  int         n_tests = 0;
  row_s       rows [14];

  ////////////////////////////////////////////////////////////////////////////
  i2c_link_if i2c_link_if_inst ();
  rtc_serial_slave #(.RESET_DELAY(RD), .WRITE_TIME(WT)) rtc_serial_slave_inst (
    .clk(clk), .reset_n(reset_n), .link(i2c_link_if_inst.slave),
    .supply_low(supply_low), .on_battery(on_battery), .protect_en(protect_en),
    .reset_out_n(reset_out_n), .write_busy(write_busy));
  // short link half period keeps the run well inside the cycle budget
  i2c_bus_master #(.HALF(10)) i2c_bus_master_inst (
    .clk(clk), .reset_n(reset_n), .link(i2c_link_if_inst.master),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .nack(nack), .busy(busy));
  rtc_link_assertions rtc_link_assertions_inst (
    .clk(clk), .reset_n(reset_n), .scl_oe_n(i2c_link_if_inst.scl_oe_n),
    .sda_m_oe_n(i2c_link_if_inst.sda_m_oe_n), .sda_s_oe_n(i2c_link_if_inst.sda_s_oe_n),
    .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  // entered just after a rising edge; each byte held until ready is seen
  task automatic send_txn(input int n, input logic [159:0] b);
    int k;
    for (k = 0; k < n; k++) begin
      cmd_data  <= {1'(k == n - 1), b[8*(n-1-k) +: 8]};
      cmd_valid <= 1'b1;
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
  endtask : send_txn

  task automatic end_txn(input logic nk, input logic wb, input bit drain);
    // the master only starts on its next link tick, so wait for it to pick the bytes up
    while (busy !== 1'b1) @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
    repeat (20) @(negedge clk);
    check_bit("nack", nk, nack);
    check_bit("write_busy", wb, write_busy);
    if (drain) while (write_busy !== 1'b0) @(negedge clk);
    @(posedge clk);
  endtask : end_txn

  task automatic wait_release();
    int c;
    c = 0;
    while (reset_out_n !== 1'b1) begin
      @(negedge clk);
      c++;
    end
    check_bit("release delay", 1'b1, 1'(c >= RD && c <= RD + 8));
    @(posedge clk);
  endtask : wait_release

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin : watchdog
    repeat (100000) @(posedge clk);
    miscompares++;
    $display("ERROR watchdog expected finished seen running");
    print_verdict();
  end

  initial begin : main
    int i;
    reset_n    = 1'b0;
    supply_low = 1'b0;
    on_battery = 1'b0;
    protect_en = 1'b0;
    cmd_data   = 9'h000;
    cmd_valid  = 1'b0;
    rows[0]  = '{8'h04, 160'hAE001055, 1'b0, 1'b0, 1'b1};
    rows[1]  = '{8'h01, 160'hA0, 1'b0, 1'b1, 1'b0};
    rows[2]  = '{8'h01, 160'hAA, 1'b0, 1'b1, 1'b0};
    rows[3]  = '{8'h01, 160'h5E, 1'b0, 1'b1, 1'b0};
    rows[4]  = '{8'h04, 160'hDE003F02, 1'b0, 1'b0, 1'b0};
    rows[5]  = '{8'h04, 160'hDE003F06, 1'b0, 1'b0, 1'b0};
    rows[6]  = '{8'h04, 160'hDE003F00, 1'b0, 1'b0, 1'b0};
    rows[7]  = '{8'h0B, 160'hDE0030_0102030405060708, 1'b0, 1'b0, 1'b0};
    rows[8]  = '{8'h04, 160'hDE003F02, 1'b0, 1'b0, 1'b0};
    rows[9]  = '{8'h04, 160'hDE003F06, 1'b0, 1'b0, 1'b0};
    rows[10] = '{8'h0B, 160'hDE0030_1112131415161718, 1'b0, 1'b0, 1'b1};
    rows[11] = '{8'h14, 160'hAE0010_A0A1A2A3A4A5A6A7A8A9AAABACADAEAFB0, 1'b0, 1'b0, 1'b1};
    rows[12] = '{8'h04, 160'hAE018077, 1'b1, 1'b0, 1'b0};
    rows[13] = '{8'h03, 160'hAE0010, 1'b0, 1'b0, 1'b0};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check_bit("reset_out_n", 1'b0, reset_out_n);
    wait_release();
    $display("reset test done");

    for (i = 0; i < 14; i++) begin
      protect_en <= rows[i].prot;
      send_txn(rows[i].n, rows[i].b);
      end_txn(rows[i].nk, rows[i].wb, 1'b1);
      $display("row %0d done", i);
    end
    check_byte("array 010", 8'hB0, rtc_serial_slave_inst.array_mem[9'h010]);
    check_byte("array 01F", 8'hAF, rtc_serial_slave_inst.array_mem[9'h01F]);
    check_byte("reg 30", 8'h11, rtc_serial_slave_inst.reg_mem[6'h30]);
    check_byte("reg 37", 8'h18, rtc_serial_slave_inst.reg_mem[6'h37]);

    // polling with the array byte while the write cycle still runs
    send_txn(4, 160'hAE001155);
    end_txn(1'b0, 1'b1, 1'b0);
    send_txn(1, 160'hAE);
    end_txn(1'b1, 1'b1, 1'b1);
    send_txn(1, 160'hAE);
    end_txn(1'b0, 1'b0, 1'b1);
    check_byte("array 011", 8'h55, rtc_serial_slave_inst.array_mem[9'h011]);
    $display("polling test done");

    // low supply refuses the whole transaction
    supply_low <= 1'b1;
    send_txn(4, 160'hAE001255);
    end_txn(1'b1, 1'b0, 1'b1);
    check_bit("reset_out_n", 1'b0, reset_out_n);
    supply_low <= 1'b0;
    wait_release();
    $display("low supply test done");

    // supply drop mid write cycle: survives on main supply, aborts on battery
    for (i = 0; i < 2; i++) begin
      // the battery pass sends a different byte, which must never land
      send_txn(4, 160'hAE002066 + 160'(i));
      end_txn(1'b0, 1'b1, 1'b0);
      supply_low <= 1'b1;
      on_battery <= i[0];
      repeat (10) @(negedge clk);
      check_bit("write_busy held", ~i[0], write_busy);
      while (write_busy !== 1'b0) @(negedge clk);
      @(posedge clk);
      supply_low <= 1'b0;
      on_battery <= 1'b0;
      wait_release();
      $display("supply drop test %0d done", i);
    end
    check_byte("array 020", 8'h66, rtc_serial_slave_inst.array_mem[9'h020]);
    print_verdict();
  end
endmodule : rtc_eeprom_serial_slave_bench
`default_nettype wire

/* File: testbench/rtc_link_assertions.sv */
// wire-level checker for the link between the master end and the slave end
// assumes write traffic only and a link half period of at least 8 clocks
`timescale 1ns/1ps
`default_nettype none
module rtc_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link
  input wire logic scl_oe_n,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic       scl_d;
  logic       sda_d;
  logic       start_w;
  logic [3:0] bit_cnt;
  assign start_w = scl_d & scl & sda_d & ~sda;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    scl_d <= scl;
    sda_d <= sda;
  end

  // clock pulses within the current nine-bit slot, restarted by every start
  always_ff @(posedge clk) begin
    if (!reset_n || start_w) begin
      bit_cnt <= 4'h0;
    end else if (scl && !scl_d) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence stop_seq;
    scl_d && scl && !sda_d && sda;
  endsequence
  sequence ack_pulse_seq;
    ##[1:60] $rose(scl) ##[1:60] $fell(scl);
  endsequence

  AST_ACK_ON_NINTH: assert property ($fell(sda_s_oe_n) |-> bit_cnt == 4'h8)
    else $error("slave pulled data low outside the ninth bit");
  AST_ACK_SCL_LOW: assert property ($fell(sda_s_oe_n) |-> !scl)
    else $error("slave changed data while clock high");
  AST_ACK_CLOCKED: assert property ($fell(sda_s_oe_n) |-> ack_pulse_seq)
    else $error("acknowledge bit not clocked in time");
  AST_ACK_HELD: assert property ($fell(sda_s_oe_n) |-> !sda_s_oe_n until $fell(scl))
    else $error("acknowledge dropped before clock fell");
  AST_MASTER_RELEASED: assert property (!sda_s_oe_n && scl |-> sda_m_oe_n)
    else $error("master drives data during acknowledge");
  AST_MASTER_OFF_EDGE: assert property ($changed(sda_m_oe_n) |-> $stable(scl_oe_n))
    else $error("master data moved with clock edge");
  AST_SLAVE_STABLE_HIGH: assert property (scl && scl_d |-> $stable(sda_s_oe_n))
    else $error("slave data moved while clock high");
  AST_QUIET_AFTER_START: assert property (start_w |-> sda_s_oe_n [*8])
    else $error("slave drove data right after start");
  AST_IDLE_AFTER_STOP: assert property (stop_seq |=> (scl && sda) [*4])
    else $error("link not idle after stop");
endmodule : rtc_link_assertions
`default_nettype wire
